// >>> include/lag_fwd_consts.vh
// Constants for the aggregation egress and uplink pass-through block.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef LAG_FWD_CONSTS_VH
`define LAG_FWD_CONSTS_VH
// Register byte addresses
`define REG_CTRL 8'h00
`define REG_GRP_SEL 8'h04
`define REG_GRP_CFG 8'h08
`define REG_PORT_SEL 8'h0C
`define REG_PORT_CFG 8'h10
`define REG_VLAN_SEL 8'h14
`define REG_VLAN_CFG 8'h18
`define REG_STATUS 8'h1C
// Hash modes
`define HMODE_L2 2'h0
`define HMODE_L3 2'h1
`define HMODE_L23 2'h2
// Group type
`define GTYPE_STATIC 1'b0
`define GTYPE_LACP 1'b1
// Fields of the control register
`define CTRL_HMODE_LO 0
`define CTRL_PT_EN 2
// Fields of the port config register
`define PC_GRP_LO 0
`define PC_IN_GRP 5
`define PC_UPLINK 6
`define PC_INGFILT 7
`define PC_MIRROR 8
`define PC_LOCK 9
`define PC_UNIT_LO 10
`define PC_PVID_LO 16
// Group config fields
`define GC_TYPE 8
`define GC_CNT_LO 0
// Largest VLAN id that may pass through
`define VID_MAX 12'hFFE
// AXI responses
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/frame_fifo.v
// Small synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module frame_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  ////////////////////////////////////////////////////////////////
  // Honest full and empty from the occupancy count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only pointers and the occupancy count need a defined value
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers wrap at depth so depth need not be a power of two
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// >>> rtl/lag_egress.v
// What this block does
// - Unicast to a group spread by header hash
// - Multicast to a group uses one member
// - Hash from MAC, IP or both pairs
// - Hash made at ingress, carried, used at egress
// - Same flow always leaves same member
// - Group type static or protocol, static at reset
// - At most 32 aggregation groups
// - Member port's own config ignored until removed
// - Pass-through forwards unknown VLANs between uplinks
// - Uplink only on stack units 1 and 2
// - Uplink port never joins a group
// - Uplink forces mirroring and lock off
// - Pass-through covers uncreated VLANs up to 4094
// - Ingress filtering drops non-member tagged frames
//
// Egress member selection for aggregation groups plus uplink pass-through.
// Assumes frames arrive as header descriptors on sys_clk from the ingress
// pipeline; software reaches the tables over AXI4-Lite.
`timescale 1ns/1ps
`include "lag_fwd_consts.vh"
module lag_egress #(
  parameter NPORT = 48,
  parameter NGRP = 32,
  parameter NVLAN = 4096,
  parameter FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Ingress descriptor
  input wire in_valid,
  output reg in_ready_q,
  input wire [47:0] in_smac,
  input wire [47:0] in_dmac,
  input wire [31:0] in_sip,
  input wire [31:0] in_dip,
  input wire in_is_ip,
  input wire in_tagged,
  input wire [11:0] in_vid,
  input wire [5:0] in_src_port,
  input wire in_dst_is_grp,
  input wire [5:0] in_dst,
  input wire in_dst_known,
  // Egress decision
  output reg out_valid_q,
  input wire out_ready,
  output reg [5:0] out_port_q,
  output reg out_drop_q,
  output reg out_mirror_q,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // Descriptor after the hash: hash 16, vid 12, tagged, mcast, grp flag, dst 6, src 6, known
  localparam DW = 44;
  // Configuration storage
  reg [1:0] hmode_q;
  reg pt_en_q;
  reg [4:0] grp_sel_q;
  reg [5:0] port_sel_q;
  reg [11:0] vlan_sel_q;
  reg [NGRP-1:0] gtype_q;
  reg [5:0] pgrp_q [0:NPORT-1];
  reg [NPORT-1:0] in_grp_q;
  reg [NPORT-1:0] uplink_q;
  reg [NPORT-1:0] ingfilt_q;
  reg [NPORT-1:0] mirror_q;
  reg [NPORT-1:0] lock_q;
  reg [2:0] unit_q [0:NPORT-1];
  reg [11:0] pvid_q [0:NPORT-1];
  reg [NVLAN-1:0] vexist_q;
  reg [NPORT-1:0] vmem_q [0:NVLAN-1];
  reg [31:0] drop_cnt_q;
  integer i;

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Fold a wide word to 16 bits; the same value for the same flow
  function [15:0] fold16;
    input [95:0] v;
    begin
      fold16 = v[15:0] ^ v[31:16] ^ v[47:32] ^ v[63:48] ^ v[79:64] ^ v[95:80];
    end
  endfunction

  // Active members of a group, in port order
  function [5:0] member_count;
    input [4:0] g;
    integer k;
    begin
      member_count = 6'h00;
      for (k = 0; k < NPORT; k = k + 1) begin
        if (in_grp_q[k] && pgrp_q[k][4:0] == g) begin
          member_count = member_count + 6'h01;
        end
      end
    end
  endfunction

  // Port that holds position idx among the group's members
  function [5:0] member_at;
    input [4:0] g;
    input [5:0] idx;
    integer k;
    reg [5:0] n;
    begin
      n = 6'h00;
      member_at = 6'h00;
      for (k = 0; k < NPORT; k = k + 1) begin
        if (in_grp_q[k] && pgrp_q[k][4:0] == g) begin
          if (n == idx) begin
            member_at = k[5:0];
          end
          n = n + 6'h01;
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Ingress stage: hash into the descriptor

  reg [15:0] hash_d;
  always @* begin
    case (hmode_q)
      `HMODE_L3: hash_d = in_is_ip ? fold16({in_sip, in_dip, 32'h0}) : fold16({in_smac, in_dmac});
      `HMODE_L23: hash_d = fold16({in_smac, in_dmac}) ^
        (in_is_ip ? fold16({in_sip, in_dip, 32'h0}) : 16'h0000);
      default: hash_d = fold16({in_smac, in_dmac});
    endcase
  end

  // Descriptor carries the hash to egress; only header fields feed it
  wire [DW-1:0] desc_in = {hash_d, in_vid, in_tagged, in_dmac[40], in_dst_is_grp,
    in_dst, in_src_port, in_dst_known};
  wire fifo_out_valid;
  wire [DW-1:0] desc_out;
  reg pop_d;
  // A descriptor is taken only on the registered ready the producer sees
  wire push_w = in_valid & in_ready_q;

  frame_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(push_w),
    .in_ready(),
    .in_data(desc_in),
    .out_valid(fifo_out_valid),
    .out_ready(pop_d),
    .out_data(desc_out)
  );

  // Own occupancy count: a registered ready must never promise a slot the FIFO lacks
  reg [3:0] occ_q;
  wire [3:0] occ_d = occ_q + {3'h0, push_w} - {3'h0, pop_d};
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      in_ready_q <= 1'b0;
      occ_q <= 4'h0;
    end else begin
      occ_q <= occ_d;
      in_ready_q <= (occ_d != FIFO_DEPTH[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Egress stage: member choice, pass-through and filtering

  wire [15:0] e_hash = desc_out[43:28];
  wire [11:0] e_vid = desc_out[27:16];
  wire e_tag = desc_out[15];
  wire e_mc = desc_out[14];
  wire e_grp = desc_out[13];
  wire [5:0] e_dst = desc_out[12:7];
  wire [5:0] e_src = desc_out[6:1];
  wire e_known = desc_out[0];
  wire [5:0] e_cnt = member_count(e_dst[4:0]);
  // Counts are recounted every frame, so membership changes apply at once
  wire [15:0] e_mod = e_hash % {10'h000, e_cnt};
  wire [5:0] e_idx = (e_cnt == 6'h00) ? 6'h00 : e_mod[5:0];
  // Multicast pinned to the first member
  wire [5:0] e_sel = e_mc ? member_at(e_dst[4:0], 6'h00) : member_at(e_dst[4:0], e_idx);
  reg [5:0] port_d;
  reg drop_d;
  reg mir_d;

  always @* begin
    port_d = e_dst;
    drop_d = 1'b0;
    mir_d = 1'b0;
    pop_d = fifo_out_valid & (~out_valid_q | out_ready);
    if (e_grp) begin
      port_d = e_sel;
      drop_d = (e_cnt == 6'h00) | (e_dst[4:0] >= NGRP);
    end else if (pt_en_q && !vexist_q[e_vid] && e_vid <= `VID_MAX) begin
      // Unknown VLAN: only between uplinks
      port_d = e_dst;
      drop_d = !(uplink_q[e_src] && uplink_q[e_dst] && e_src != e_dst);
    end else begin
      drop_d = !e_known;
    end
    // Member ports follow the group, not their own filter
    // The membership table has no reset, so an uncreated VLAN counts as no members
    if (!in_grp_q[e_src] && ingfilt_q[e_src] && e_tag &&
        !(vexist_q[e_vid] && vmem_q[e_vid][e_src]) && e_vid != pvid_q[e_src] &&
        !(pt_en_q && !vexist_q[e_vid] && uplink_q[e_src])) begin
      drop_d = 1'b1;
    end
    // Uplinks never mirror
    mir_d = mirror_q[e_src] & ~in_grp_q[e_src] & ~uplink_q[e_src];
  end

  // Output register, held until the consumer takes it
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid_q <= 1'b0;
      out_port_q <= 6'h00;
      out_drop_q <= 1'b0;
      out_mirror_q <= 1'b0;
      drop_cnt_q <= 32'h0;
    end else if (pop_d) begin
      out_valid_q <= 1'b1;
      out_port_q <= port_d;
      out_drop_q <= drop_d;
      out_mirror_q <= mir_d;
      if (drop_d) begin
        drop_cnt_q <= drop_cnt_q + 32'h1;
      end
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg aw_have_q;
  reg w_have_q;
  wire do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [31:0] pc_wr = wdata_q;
  // Uplink accepted only on units 1 and 2 and never with a group
  wire up_ok = pc_wr[`PC_UPLINK] && !pc_wr[`PC_IN_GRP] &&
    (pc_wr[`PC_UNIT_LO+2:`PC_UNIT_LO] == 3'h1 || pc_wr[`PC_UNIT_LO+2:`PC_UNIT_LO] == 3'h2);

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OK;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      hmode_q <= `HMODE_L2;
      pt_en_q <= 1'b0;
      grp_sel_q <= 5'h00;
      port_sel_q <= 6'h00;
      vlan_sel_q <= 12'h000;
      gtype_q <= {NGRP{`GTYPE_STATIC}};
      in_grp_q <= {NPORT{1'b0}};
      uplink_q <= {NPORT{1'b0}};
      ingfilt_q <= {NPORT{1'b0}};
      mirror_q <= {NPORT{1'b0}};
      lock_q <= {NPORT{1'b0}};
      vexist_q <= {NVLAN{1'b0}};
      for (i = 0; i < NPORT; i = i + 1) begin
        pgrp_q[i] <= 6'h00;
        unit_q[i] <= 3'h0;
        pvid_q[i] <= 12'h001;
      end
    end else begin
      // Take address and data in either order, one write at a time
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OK;
        case (awaddr_q)
          `REG_CTRL: begin
            hmode_q <= (pc_wr[1:0] == 2'h3) ? `HMODE_L2 : pc_wr[1:0];
            pt_en_q <= pc_wr[`CTRL_PT_EN];
          end
          `REG_GRP_SEL: grp_sel_q <= pc_wr[4:0];
          `REG_GRP_CFG: gtype_q[grp_sel_q] <= pc_wr[`GC_TYPE];
          `REG_PORT_SEL: port_sel_q <= (pc_wr[5:0] < NPORT) ? pc_wr[5:0] : 6'h00;
          `REG_PORT_CFG: begin
            pgrp_q[port_sel_q] <= {1'b0, pc_wr[`PC_GRP_LO+4:`PC_GRP_LO]};
            in_grp_q[port_sel_q] <= pc_wr[`PC_IN_GRP];
            uplink_q[port_sel_q] <= up_ok;
            ingfilt_q[port_sel_q] <= pc_wr[`PC_INGFILT];
            mirror_q[port_sel_q] <= pc_wr[`PC_MIRROR] & ~up_ok;
            lock_q[port_sel_q] <= pc_wr[`PC_LOCK] & ~up_ok;
            unit_q[port_sel_q] <= pc_wr[`PC_UNIT_LO+2:`PC_UNIT_LO];
            pvid_q[port_sel_q] <= pc_wr[`PC_PVID_LO+11:`PC_PVID_LO];
          end
          `REG_VLAN_SEL: vlan_sel_q <= pc_wr[11:0];
          `REG_VLAN_CFG: vexist_q[vlan_sel_q] <= pc_wr[0];
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
    end
  end

  // VLAN membership table kept outside the reset tree to save area
  always @(posedge sys_clk) begin
    if (do_write && awaddr_q == `REG_VLAN_CFG) begin
      vmem_q[vlan_sel_q] <= {wdata_q[31:1], 17'h0} >> 17 | {NPORT{1'b0}};
    end
  end

  // Read channel: one read at a time, answer one cycle after the address
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OK;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= {29'h0, pt_en_q, hmode_q};
          `REG_GRP_SEL: s_axi_rdata <= {27'h0, grp_sel_q};
          `REG_GRP_CFG: s_axi_rdata <= {23'h0, gtype_q[grp_sel_q], 2'h0, member_count(grp_sel_q)};
          `REG_PORT_SEL: s_axi_rdata <= {26'h0, port_sel_q};
          `REG_PORT_CFG: s_axi_rdata <= {4'h0, pvid_q[port_sel_q], 3'h0, unit_q[port_sel_q],
            lock_q[port_sel_q], mirror_q[port_sel_q], ingfilt_q[port_sel_q],
            uplink_q[port_sel_q], in_grp_q[port_sel_q], pgrp_q[port_sel_q][4:0]};
          `REG_VLAN_SEL: s_axi_rdata <= {20'h0, vlan_sel_q};
          `REG_VLAN_CFG: s_axi_rdata <= {15'h0, vexist_q[vlan_sel_q], 16'h0};
          `REG_STATUS: s_axi_rdata <= drop_cnt_q;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule

// >>> verification/egress_sink.sv
// Model of the egress consumer: takes decisions with random stalls.
// Assumes the bench seeds $urandom; one clock, async active-low reset.
`timescale 1ns/1ps
module egress_sink (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Decision handshake
  input wire out_valid_q,
  output reg out_ready
);
  ////////////////////////////////////////////////////////////////
  // Stalls a third of the time so the held decision is exercised
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= ($urandom % 3) != 0;
    end
  end
endmodule

// >>> verification/lag_egress_assertions.sv
// Checker for the aggregation egress block, watching its top ports.
// Assumes one clock and an async active-low reset; bound from tb_top.
`timescale 1ns/1ps
module lag_egress_chk (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Descriptor stream
  input wire in_valid,
  input wire in_ready_q,
  input wire out_valid_q,
  input wire out_ready,
  input wire [5:0] out_port_q,
  input wire out_drop_q,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // A stalled decision must not move, or one flow could change member
  a_out_hold: assert property (out_valid_q && !out_ready |=> out_valid_q
    && $stable(out_port_q) && $stable(out_drop_q)) else $error("decision moved");
  a_port_range: assert property (out_valid_q && !out_drop_q |-> out_port_q < 6'd48)
    else $error("port out of range");
  a_stream_lat: assert property (in_valid && in_ready_q && !out_valid_q
    |-> ##[1:12] out_valid_q) else $error("descriptor lost");
  // Register bus handshakes
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready not a pulse");
  // Main scenarios
  cover property (out_valid_q && out_ready && !out_drop_q);
  cover property (out_valid_q && !out_ready);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the aggregation egress block.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "lag_fwd_consts.vh"
module tb_top;
  reg sys_clk, nrst, in_valid, in_is_ip, in_tagged, in_dst_is_grp, in_dst_known;
  reg [47:0] in_smac, in_dmac;
  reg [31:0] in_sip, in_dip, s_axi_wdata, rd_d, sm, dm;
  reg [11:0] in_vid;
  reg [5:0] in_src_port, in_dst, pa, pb;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [3:0] s_axi_wstrb;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, da, db;
  reg [1:0] rsp, seen;
  wire in_ready_q, out_valid_q, out_ready, out_drop_q, out_mirror_q;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [5:0] out_port_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int num_errors, total_checks, cyc, i;

  lag_egress i_dut (.sys_clk(sys_clk), .nrst(nrst), .in_valid(in_valid),
    .in_ready_q(in_ready_q), .in_smac(in_smac), .in_dmac(in_dmac), .in_sip(in_sip),
    .in_dip(in_dip), .in_is_ip(in_is_ip), .in_tagged(in_tagged), .in_vid(in_vid),
    .in_src_port(in_src_port), .in_dst_is_grp(in_dst_is_grp), .in_dst(in_dst),
    .in_dst_known(in_dst_known), .out_valid_q(out_valid_q), .out_ready(out_ready),
    .out_port_q(out_port_q), .out_drop_q(out_drop_q), .out_mirror_q(out_mirror_q),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  egress_sink i_sink (.sys_clk(sys_clk), .nrst(nrst), .out_valid_q(out_valid_q),
    .out_ready(out_ready));

  ////////////////////////////////////////////////////////////////
  // Clock and hang guard; the ceiling is well above the planned run
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      end_sim;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Tasks and expectation helpers
  function automatic [31:0] pcfg(input [4:0] g, input [4:0] fl, input [2:0] u);
    pcfg = {4'h0, 12'h001, 3'h0, u, fl, 5'h0} | {27'h0, g}; // fl: lock,mir,filt,up,in
  endfunction
  task chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // One descriptor in, its decision out
  task send(input [31:0] s, d, input [11:0] v, input [5:0] src, dst, input g, k,
      output [5:0] p, output dr);
    // Source IP is rotated so the MAC and IP folds cannot cancel in the combined mode
    {in_smac, in_dmac, in_sip, in_dip} <= {16'h0, s, d[31:24], 8'h0, d, {s[30:0], s[31]}, d};
    {in_vid, in_src_port, in_dst, in_dst_is_grp, in_dst_known} <= {v, src, dst, g, k};
    in_valid <= 1'b1;
    do @(posedge sys_clk); while (!in_ready_q);
    in_valid <= 1'b0;
    do @(posedge sys_clk); while (!(out_valid_q && out_ready));
    p = out_port_q;
    dr = out_drop_q;
  endtask
  task end_sim;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h76C90E56));
    {in_valid, in_dst_is_grp, in_dst_known, in_smac, in_dmac, in_sip, in_dip} = '0;
    {in_vid, in_src_port, in_dst, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {in_is_ip, in_tagged, s_axi_wstrb, nrst, seen} = {6'h3F, 1'b0, 2'h0};
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(`REG_GRP_CFG);
    chk(rd_d[8] === `GTYPE_STATIC, "group type after reset");
    for (i = 0; i < 3; i++) begin
      wr(`REG_CTRL, i);
      rd(`REG_CTRL);
      chk(rd_d[2:0] === i[2:0], "hash mode");
    end
    wr(`REG_GRP_SEL, 32'h1F);
    wr(`REG_GRP_CFG, 32'h100);
    rd(`REG_GRP_CFG);
    chk(rd_d[8] === `GTYPE_LACP, "last group type");
    rd(8'h20);
    chk(rsp === `RESP_SLVERR, "unmapped read");
    wr(8'h20, 32'h1);
    chk(rsp === `RESP_SLVERR, "unmapped write");
    // Ports 4 and 5 join group 31 from the default VLAN; port 4's mirror must be ignored
    for (i = 4; i < 6; i++) begin
      wr(`REG_PORT_SEL, i);
      wr(`REG_PORT_CFG, pcfg(5'h1F, (i == 4) ? 5'h09 : 5'h01, 3'h1));
    end
    rd(`REG_GRP_CFG);
    chk(rd_d[5:0] === 6'h02, "member count");
    // Multicast sent from the mirrored member itself
    for (i = 0; i < 4; i++) begin
      send($urandom, $urandom | 32'h0100_0000, 12'h001, 6'h04, 6'h1F, 1'b1, 1'b1, pa, da);
      chk(pa === 6'h04 && da === 1'b0, "multicast member");
      chk(out_mirror_q === 1'b0, "member mirror");
    end
    // Each hash mode in turn: a flow keeps its member, flows reach both members
    for (i = 0; i < 18; i++) begin
      wr(`REG_CTRL, i % 3);
      sm = $urandom;
      dm = $urandom & 32'hFEFF_FFFF;
      send(sm, dm, 12'h001, 6'h07, 6'h1F, 1'b1, 1'b1, pa, da);
      send(sm, dm, 12'h001, 6'h07, 6'h1F, 1'b1, 1'b1, pb, db);
      chk(pa === pb, "flow changed member");
      chk((pa === 6'h04 || pa === 6'h05) && da === 1'b0, "unicast member");
      seen = seen | ((pa == 6'h04) ? 2'h1 : 2'h2);
    end
    chk(seen === 2'h3, "no spreading");
    // Uplinks: units 1 and 2 only, never a member, mirror and lock forced off
    wr(`REG_PORT_SEL, 32'h1);
    wr(`REG_PORT_CFG, pcfg(5'h0, 5'h1E, 3'h1));
    rd(`REG_PORT_CFG);
    chk(rd_d[9:6] === 4'h3, "uplink side bits");
    wr(`REG_PORT_SEL, 32'h2);
    wr(`REG_PORT_CFG, pcfg(5'h0, 5'h06, 3'h2));
    wr(`REG_PORT_SEL, 32'h3);
    wr(`REG_PORT_CFG, pcfg(5'h0, 5'h0E, 3'h3));
    rd(`REG_PORT_CFG);
    chk(rd_d[8:6] === 3'h6, "uplink on unit 3");
    wr(`REG_PORT_SEL, 32'h4);
    wr(`REG_PORT_CFG, pcfg(5'h1F, 5'h03, 3'h1));
    rd(`REG_PORT_CFG);
    chk(rd_d[6:5] === 2'h1, "uplink on member");
    wr(`REG_CTRL, 32'h6);
    send($urandom, 32'h2, 12'd500, 6'h01, 6'h02, 1'b0, 1'b0, pa, da);
    chk(pa === 6'h02 && da === 1'b0, "pass-through 500");
    chk(out_mirror_q === 1'b0, "uplink mirror");
    send($urandom, 32'h1, 12'd4094, 6'h02, 6'h01, 1'b0, 1'b0, pa, da);
    chk(pa === 6'h01 && da === 1'b0, "pass-through 4094");
    send($urandom, 32'h2, 12'd500, 6'h03, 6'h02, 1'b0, 1'b0, pa, da);
    chk(da === 1'b1, "pass-through from non-uplink");
    chk(out_mirror_q === 1'b1, "mirror on plain port");
    wr(`REG_VLAN_SEL, 32'd500);
    wr(`REG_VLAN_CFG, 32'hD);
    send($urandom, 32'h2, 12'd500, 6'h01, 6'h02, 1'b0, 1'b1, pa, da);
    chk(pa === 6'h02 && da === 1'b0, "created VLAN forwarding");
    wr(`REG_CTRL, 32'h2);
    send($urandom, 32'h2, 12'd600, 6'h01, 6'h02, 1'b0, 1'b1, pa, da);
    chk(da === 1'b1, "ingress filter");
    end_sim;
  end
endmodule

bind lag_egress lag_egress_chk i_chk (.sys_clk(sys_clk), .nrst(nrst), .in_valid(in_valid),
  .in_ready_q(in_ready_q), .out_valid_q(out_valid_q), .out_ready(out_ready),
  .out_port_q(out_port_q), .out_drop_q(out_drop_q), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
